//--- mmd_decoder.v
// Memory map decoder and wait-state controller for the CPU memory bus
`timescale 1ns/1ps
`include "mmd_memory_map.vh"

module mmd_decoder #(
	parameter LARGE_FLASH = 1,
	parameter WW          = 4
) (
	// Clock and reset
	input  wire              clk,
	input  wire              reset_n,
	// CPU memory bus
	input  wire              busReq,
	input  wire [21:0]       busAddr,
	input  wire              busWrite,
	input  wire              busDataSpace,
	input  wire              busIoSpace,
	output wire              busReady,
	// Configuration
	input  wire [WW-1:0]     flashWait,
	input  wire [WW-1:0]     otpWait,
	input  wire [WW-1:0]     zone0Wait,
	input  wire [WW-1:0]     zone1Wait,
	input  wire [WW-1:0]     zone2Wait,
	input  wire [WW-1:0]     zone6Wait,
	input  wire [WW-1:0]     zone7Wait,
	input  wire [4:0]        zoneUseReady,
	input  wire              protModeWrite,
	input  wire              protModeData,
	input  wire              bootModeWrite,
	input  wire              bootModeData,
	// Status
	output reg               protMode_r,
	output reg               bootSourceModeBit_r,
	output wire              vectorsExternal,
	// Pins
	input  wire              bootSourceSelectPin,
	input  wire              extReady,
	output reg               zone01Select_n_r,
	output reg               zone2Select_n_r,
	output reg               zone67Select_n_r,
	// Region selects of the current access
	output reg               selRamA_r,
	output reg               selRamB_r,
	output reg               selLocalA_r,
	output reg               selLocalB_r,
	output reg               selHighRam_r,
	output reg               selPf0_r,
	output reg               selPf1_r,
	output reg               selPf2_r,
	output reg               selOtp_r,
	output reg               selFlash_r,
	output reg [3:0]         flashSector_r,
	output reg               selBootEntry_r,
	output reg               selPassword_r,
	output reg               selBootRom_r,
	output reg [4:0]         selZone_r,
	output reg               decodeMiss_r
);

	// ----------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------
	reg       pinMeta_r;
	reg       pinSync_r;
	reg       rdyMeta_r;
	reg       rdySync_r;
	reg [1:0] strapCnt_r;
	reg       strapDone_r;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_r <= 1'b0;
			pinSync_r <= 1'b0;
			rdyMeta_r <= 1'b0;
			rdySync_r <= 1'b0;
		end else begin
			pinMeta_r <= bootSourceSelectPin;
			pinSync_r <= pinMeta_r;
			rdyMeta_r <= extReady;
			rdySync_r <= rdyMeta_r;
		end
	end

	// Strap is taken once the synchroniser has flushed after release
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapCnt_r          <= 2'h0;
			strapDone_r         <= 1'b0;
			bootSourceModeBit_r <= 1'b0;
			protMode_r          <= 1'b1;
		end else begin
			if (protModeWrite)
				protMode_r <= protModeData;
			if (!strapDone_r) begin
				strapCnt_r <= strapCnt_r + 2'h1;
				if (strapCnt_r == `MMD_STRAP_DLY) begin
					strapDone_r         <= 1'b1;
					bootSourceModeBit_r <= pinSync_r;
				end
			end else if (bootModeWrite) begin
				bootSourceModeBit_r <= bootModeData;
			end
		end
	end

	assign vectorsExternal = bootSourceModeBit_r;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire mem     = !busIoSpace;
	wire dat     = busDataSpace && mem;
	wire mode    = bootSourceModeBit_r;
	wire flLo    = (LARGE_FLASH != 0) ? (busAddr >= `MMD_FL_LARGE_LO)
	                                  : (busAddr >= `MMD_FL_SMALL_LO);
	wire dRamA   = mem && busAddr <= `MMD_RAMA_HI;
	wire dRamB   = mem && busAddr >= `MMD_RAMB_LO && busAddr <= `MMD_RAMB_HI;
	wire dPf0    = dat && busAddr >= `MMD_PF0_LO && busAddr <= `MMD_PF0_HI;
	wire dPf1    = dat && busAddr >= `MMD_PF1_LO && busAddr <= `MMD_PF1_HI;
	wire dPf2    = dat && busAddr >= `MMD_PF2_LO && busAddr <= `MMD_PF2_HI;
	wire dLocA   = mem && busAddr >= `MMD_LRA_LO && busAddr <= `MMD_LRA_HI;
	wire dLocB   = mem && busAddr >= `MMD_LRB_LO && busAddr <= `MMD_LRB_HI;
	wire dHigh   = mem && busAddr >= `MMD_HRAM_LO && busAddr <= `MMD_HRAM_HI;
	wire dOtp    = mem && busAddr >= `MMD_OTP_LO && busAddr <= `MMD_OTP_HI;
	wire dFlash  = mem && flLo && busAddr <= `MMD_FL_HI;
	wire dEntry  = mem && busAddr >= `MMD_ENTRY_LO && busAddr <= `MMD_ENTRY_HI;
	wire dPwd    = mem && busAddr >= `MMD_PWD_LO && busAddr <= `MMD_PWD_HI;
	// Only these two decodes look at the mode bit
	wire dBrom   = mem && !mode && busAddr >= `MMD_BROM_LO;
	wire [4:0] dZone;
	assign dZone[0] = mem && busAddr >= `MMD_Z0_LO && busAddr <= `MMD_Z0_HI;
	assign dZone[1] = mem && busAddr >= `MMD_Z1_LO && busAddr <= `MMD_Z1_HI;
	assign dZone[2] = mem && busAddr >= `MMD_Z2_LO && busAddr <= `MMD_Z2_HI;
	assign dZone[3] = mem && busAddr >= `MMD_Z6_LO && busAddr <= `MMD_Z6_HI;
	assign dZone[4] = mem && mode && busAddr >= `MMD_Z7_LO;
	wire dProt   = dPf1 || dPf2 || dZone[1];
	wire dHit    = dRamA || dRamB || dPf0 || dPf1 || dPf2 || dLocA || dLocB || dHigh
	               || dOtp || dFlash || dBrom || (|dZone);

	// Sector index: A is 0, J is 9
	reg [3:0] sector;
	always @* begin
		if (busAddr >= `MMD_SEC_A)      sector = 4'h0;
		else if (busAddr >= `MMD_SEC_B) sector = 4'h1;
		else if (busAddr >= `MMD_SEC_C) sector = 4'h2;
		else if (busAddr >= `MMD_SEC_D) sector = 4'h3;
		else if (busAddr >= `MMD_SEC_E) sector = 4'h4;
		else if (busAddr >= `MMD_SEC_F) sector = 4'h5;
		else if (busAddr >= `MMD_SEC_G) sector = 4'h6;
		else if (busAddr >= `MMD_SEC_H) sector = 4'h7;
		else if (busAddr >= `MMD_SEC_I) sector = 4'h8;
		else                             sector = 4'h9;
	end

	// ----------------------------------------
	// Wait count of the decoded region
	// ----------------------------------------
	reg [WW-1:0]       zw;
	reg [`MMD_CW-1:0]  waits;
	reg                useRdy;

	always @* begin
		zw     = zone0Wait;
		useRdy = 1'b0;
		// Zone 0 is the default, so its wait count needs no branch of its own
		if (dZone[1]) begin
			zw     = zone1Wait;
			useRdy = zoneUseReady[1];
		end else if (dZone[2]) begin
			zw     = zone2Wait;
			useRdy = zoneUseReady[2];
		end else if (dZone[3]) begin
			zw     = zone6Wait;
			useRdy = zoneUseReady[3];
		end else if (dZone[4]) begin
			zw     = zone7Wait;
			useRdy = zoneUseReady[4];
		end else if (dZone[0]) begin
			useRdy = zoneUseReady[0];
		end
		if (dPwd && !busWrite)
			waits = `MMD_WS_PWD;
		else if (dFlash)
			waits = {{(`MMD_CW-WW){1'b0}}, flashWait};
		else if (dOtp)
			waits = (otpWait == {WW{1'b0}}) ? `MMD_WS_ONE
			        : {{(`MMD_CW-WW){1'b0}}, otpWait};
		else if (dBrom)
			waits = `MMD_WS_BROM;
		else if ((dPf1 || dPf2) && !busWrite)
			waits = `MMD_WS_PF_READ;
		else if (|dZone)
			waits = (zw == {WW{1'b0}}) ? `MMD_WS_ONE
			        : {{(`MMD_CW-WW){1'b0}}, zw};
		else
			waits = `MMD_WS_ZERO;
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	reg [1:0]          state_r;
	reg [`MMD_CW-1:0]  cnt_r;
	reg                useRdy_r;
	reg                protWrPend_r;
	reg [21:0]         protAddr_r;

	// A protected read behind a protected write to another word waits longer
	wire needOrder = protMode_r && dProt && !busWrite && protWrPend_r
	                 && (busAddr != protAddr_r);
	wire rdyOk     = !useRdy_r || rdySync_r;

	// Wait count of the access about to be taken, ordering penalty included
	wire [`MMD_CW-1:0] total  = needOrder ? waits + `MMD_PROT_EXTRA : waits;
	// Zero-wait regions skip the wait state and answer in the cycle after the take
	wire               noWait = (total == `MMD_WS_ZERO);

	// Ready stands for one cycle; busReq is not taken again until the sequencer is idle
	assign busReady = (state_r == `MMD_ST_DONE);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r          <= `MMD_ST_IDLE;
			cnt_r            <= `MMD_WS_ZERO;
			useRdy_r         <= 1'b0;
			protWrPend_r     <= 1'b0;
			protAddr_r       <= 22'h000000;
			zone01Select_n_r <= 1'b1;
			zone2Select_n_r  <= 1'b1;
			zone67Select_n_r <= 1'b1;
			selRamA_r        <= 1'b0;
			selRamB_r        <= 1'b0;
			selLocalA_r      <= 1'b0;
			selLocalB_r      <= 1'b0;
			selHighRam_r     <= 1'b0;
			selPf0_r         <= 1'b0;
			selPf1_r         <= 1'b0;
			selPf2_r         <= 1'b0;
			selOtp_r         <= 1'b0;
			selFlash_r       <= 1'b0;
			flashSector_r    <= 4'h0;
			selBootEntry_r   <= 1'b0;
			selPassword_r    <= 1'b0;
			selBootRom_r     <= 1'b0;
			selZone_r        <= 5'h00;
			decodeMiss_r     <= 1'b0;
		end else begin
			case (state_r)
			`MMD_ST_IDLE: begin
				if (busReq) begin
					// The counter holds the waits still to come after this one
					cnt_r            <= noWait ? `MMD_WS_ZERO : total - `MMD_WS_ONE;
					useRdy_r         <= useRdy;
					state_r          <= noWait ? `MMD_ST_DONE : `MMD_ST_WAIT;
					zone01Select_n_r <= !(dZone[0] || dZone[1]);
					zone2Select_n_r  <= !dZone[2];
					zone67Select_n_r <= !(dZone[3] || dZone[4]);
					selRamA_r        <= dRamA;
					selRamB_r        <= dRamB;
					selLocalA_r      <= dLocA;
					selLocalB_r      <= dLocB;
					selHighRam_r     <= dHigh;
					selPf0_r         <= dPf0;
					selPf1_r         <= dPf1;
					selPf2_r         <= dPf2;
					selOtp_r         <= dOtp;
					selFlash_r       <= dFlash;
					flashSector_r    <= dFlash ? sector : 4'h0;
					selBootEntry_r   <= dEntry;
					selPassword_r    <= dPwd;
					selBootRom_r     <= dBrom;
					selZone_r        <= dZone;
					decodeMiss_r     <= !dHit;
					if (dProt && protMode_r)
						protWrPend_r <= busWrite;
					if (dProt && busWrite)
						protAddr_r <= busAddr;
				end
			end
			`MMD_ST_WAIT: begin
				// On the last wait a zone access with its zoneUseReady bit set stalls here while synchronised external ready is low
				if (cnt_r != `MMD_WS_ZERO)
					cnt_r <= cnt_r - `MMD_WS_ONE;
				else if (rdyOk)
					state_r <= `MMD_ST_DONE;
			end
			`MMD_ST_DONE: begin
				state_r          <= `MMD_ST_IDLE;
				zone01Select_n_r <= 1'b1;
				zone2Select_n_r  <= 1'b1;
				zone67Select_n_r <= 1'b1;
			end
			default: begin
				state_r <= `MMD_ST_IDLE;
			end
			endcase
		end
	end

endmodule

//--- mmd_memory_map.vh
// Address map, wait-state figures and state codes for the memory map decoder
`ifndef MMD_MEMORY_MAP_VH
`define MMD_MEMORY_MAP_VH

// ----------------------------------------
// Address width, on-chip RAM / frames, zones, OTP and boot ROM
// ----------------------------------------
`define MMD_AW            22
`define MMD_RAMA_LO       22'h000000
`define MMD_RAMA_HI       22'h0003FF
`define MMD_RAMB_LO       22'h000400
`define MMD_RAMB_HI       22'h0007FF
`define MMD_PF0_LO        22'h000800
`define MMD_PF0_HI        22'h000FFF
`define MMD_Z0_LO         22'h002000
`define MMD_Z0_HI         22'h003FFF
`define MMD_Z1_LO         22'h004000
`define MMD_Z1_HI         22'h005FFF
`define MMD_PF1_LO        22'h006000
`define MMD_PF1_HI        22'h006FFF
`define MMD_PF2_LO        22'h007000
`define MMD_PF2_HI        22'h007FFF
`define MMD_LRA_LO        22'h008000
`define MMD_LRA_HI        22'h008FFF
`define MMD_LRB_LO        22'h009000
`define MMD_LRB_HI        22'h009FFF
`define MMD_Z2_LO         22'h080000
`define MMD_Z2_HI         22'h0FFFFF
`define MMD_Z6_LO         22'h100000
`define MMD_Z6_HI         22'h17FFFF
`define MMD_OTP_LO        22'h3D7800
`define MMD_OTP_HI        22'h3D7BFF
`define MMD_HRAM_LO       22'h3F8000
`define MMD_HRAM_HI       22'h3F9FFF
`define MMD_Z7_LO         22'h3FC000
`define MMD_BROM_LO       22'h3FF000
`define MMD_TOP           22'h3FFFFF

// ----------------------------------------
// Flash sectors and security words
// ----------------------------------------
`define MMD_FL_LARGE_LO   22'h3D8000
`define MMD_FL_SMALL_LO   22'h3E8000
`define MMD_SEC_I         22'h3DA000
`define MMD_SEC_H         22'h3DC000
`define MMD_SEC_G         22'h3E0000
`define MMD_SEC_F         22'h3E4000
`define MMD_SEC_E         22'h3E8000
`define MMD_SEC_D         22'h3EC000
`define MMD_SEC_C         22'h3F0000
`define MMD_SEC_B         22'h3F4000
`define MMD_SEC_A         22'h3F6000
`define MMD_FL_HI         22'h3F7FFF
`define MMD_CSM_CLR_LO    22'h3F7F80
`define MMD_CSM_CLR_HI    22'h3F7FF5
`define MMD_ENTRY_LO      22'h3F7FF6
`define MMD_ENTRY_HI      22'h3F7FF7
`define MMD_PWD_LO        22'h3F7FF8
`define MMD_PWD_HI        22'h3F7FFF

// ----------------------------------------
// Wait states (cycles)
// ----------------------------------------
`define MMD_CW            5
`define MMD_WS_ZERO       5'h00
`define MMD_WS_ONE        5'h01
`define MMD_WS_PF_READ    5'h02
`define MMD_WS_PWD        5'h10
`define MMD_WS_BROM       5'h01
`define MMD_PROT_EXTRA    5'h01
`define MMD_STRAP_DLY     2'h2

// ----------------------------------------
// States
// ----------------------------------------
`define MMD_ST_IDLE       2'h0
`define MMD_ST_WAIT       2'h1
`define MMD_ST_DONE       2'h2

`endif

//--- mmd_decoder_checker.sv
// Concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
`include "mmd_memory_map.vh"
module mmd_decoder_checker (
	// Bus
	input wire        clk,
	input wire        reset_n,
	input wire        busReq,
	input wire [21:0] busAddr,
	input wire        busWrite,
	input wire        busDataSpace,
	input wire        busIoSpace,
	input wire        busReady,
	// Status and selects
	input wire        protMode_r,
	input wire        bootSourceModeBit_r,
	input wire        vectorsExternal,
	input wire        zone01Select_n_r,
	input wire        zone2Select_n_r,
	input wire        zone67Select_n_r,
	input wire        selPf0_r,
	input wire        selFlash_r,
	input wire [3:0]  flashSector_r,
	input wire [4:0]  selZone_r
);
	// ----------------------------------------
	// Access tracking
	// ----------------------------------------
	reg         busy_r;
	wire        take = busReq && !busy_r;
	wire        mem  = take && !busIoSpace;
	wire [21:0] a    = busAddr;
	// The decoder is idle for a cycle after ready before it takes again
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			busy_r <= 1'b0;
		else
			busy_r <= take ? 1'b1 : (busReady ? 1'b0 : busy_r);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_ready_one_cycle: assert property (busReady && !busReq |=> !busReady)
		else $error("ready longer than one cycle");
	chk_ram_zero_wait: assert property (mem && a <= `MMD_RAMB_HI |=> busReady)
		else $error("low ram not zero wait");
	chk_pf_read_two: assert property (mem && a >= `MMD_PF1_LO && a <= `MMD_PF2_HI
		&& !busWrite && busDataSpace |=> !busReady ##1 !busReady ##[1:2] busReady)
		else $error("frame read wait wrong");
	chk_pf_write_zero: assert property (mem && a >= `MMD_PF1_LO && a <= `MMD_PF2_HI
		&& busWrite && busDataSpace |=> busReady)
		else $error("frame write wait wrong");
	chk_pwd_sixteen: assert property (mem && a >= `MMD_PWD_LO && a <= `MMD_PWD_HI && !busWrite
		|=> !busReady [*8] ##1 !busReady [*8] ##1 busReady)
		else $error("password read wait wrong");
	chk_zone_min_one: assert property (mem && ((a >= `MMD_Z0_LO && a <= `MMD_Z1_HI)
		|| (a >= `MMD_Z2_LO && a <= `MMD_Z6_HI)) |=> !busReady
		&& !(zone01Select_n_r && zone2Select_n_r && zone67Select_n_r))
		else $error("zone access without wait or select");
	chk_mirror_low: assert property (!zone01Select_n_r |-> |selZone_r[1:0])
		else $error("shared low select without zone");
	chk_mirror_high: assert property (!zone67Select_n_r |-> |selZone_r[4:3])
		else $error("shared high select without zone");
	chk_io_no_zone: assert property (take && busIoSpace |=> busReady
		&& selZone_r == 5'h00 && zone2Select_n_r)
		else $error("io cycle reached a zone");
	chk_pf_data_only: assert property (mem && !busDataSpace && a >= `MMD_PF0_LO
		&& a <= `MMD_PF0_HI |=> !selPf0_r)
		else $error("frame decoded in program space");
	chk_sector_j: assert property (mem && a >= `MMD_FL_LARGE_LO && a < `MMD_SEC_I
		|=> selFlash_r && flashSector_r == 4'h9)
		else $error("lowest sector not decoded");
	chk_vector_mode: assert property (mem && a >= `MMD_BROM_LO && !vectorsExternal
		|=> zone67Select_n_r)
		else $error("zone 7 selected with vectors internal");
	chk_zone7_mode: assert property (mem && a >= `MMD_BROM_LO && bootSourceModeBit_r
		|=> !zone67Select_n_r)
		else $error("zone 7 not selected in mode 1");
	chk_prot_reset: assert property (!$past(reset_n) |-> protMode_r)
		else $error("protection off after reset");
endmodule

//--- mmd_ext_mem.sv
// External memory model that stretches zone accesses with its ready line
`timescale 1ns/1ps
module mmd_ext_mem #(
	parameter STALL = 3
) (
	// Clock and chip selects
	input  wire clk,
	input  wire cs01_n,
	input  wire cs2_n,
	input  wire cs67_n,
	// Ready back to the device
	output wire extReady
);
	integer cnt;
	wire    idle = cs01_n && cs2_n && cs67_n;
	initial cnt = 0;
	always @(posedge clk) begin
		if (idle)
			cnt <= 0;
		else
			cnt <= cnt + 1;
	end
	// Ready drops as soon as a select goes low; while idle the model drives ready high
	assign extReady = idle || (cnt >= STALL);
endmodule

//--- mmd_decoder_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module mmd_decoder_tb;
`define CHK(got, exp) begin total_checks = total_checks + 1; if ((got) !== (exp)) begin \
	mismatches = mismatches + 1; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
	reg        clk, reset_n, busReq, busWrite, busDataSpace, busIoSpace;
	reg [21:0] busAddr;
	reg [3:0]  flashWait, otpWait, zone0Wait, zone1Wait, zone2Wait, zone6Wait, zone7Wait;
	reg [4:0]  zoneUseReady;
	reg        protModeWrite, protModeData, bootModeWrite, bootModeData, bootSourceSelectPin;
	wire       busReady, protMode_r, bootSourceModeBit_r, vectorsExternal, extReady;
	wire       zone01Select_n_r, zone2Select_n_r, zone67Select_n_r, decodeMiss_r;
	wire       selRamA_r, selRamB_r, selLocalA_r, selLocalB_r, selHighRam_r, selPf0_r;
	wire       selPf1_r, selPf2_r, selOtp_r, selFlash_r, selBootEntry_r, selPassword_r;
	wire       selBootRom_r;
	wire [3:0] flashSector_r;
	wire [4:0] selZone_r;
	reg [32:0] rows [0:20];
	reg [32:0] r;
	reg [4:0]  n;
	reg [2:0]  s;
	integer    i, mismatches, total_checks;
	mmd_decoder #(.LARGE_FLASH(1), .WW(4)) uut (.*);
	mmd_ext_mem #(.STALL(3)) partner (.clk(clk), .cs01_n(zone01Select_n_r),
		.cs2_n(zone2Select_n_r), .cs67_n(zone67Select_n_r), .extReady(extReady));
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task stop_test;
		begin
			if (mismatches == 0 && total_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task do_reset(input pin);
		begin
			reset_n = 1'b0;
			bootSourceSelectPin = pin;
			repeat (20) @(posedge clk);
			#1;
			`CHK({busReady, protMode_r, zone01Select_n_r, zone2Select_n_r, zone67Select_n_r}, 5'h0F)
			reset_n = 1'b1;
			repeat (4) @(posedge clk);
			#1;
		end
	endtask
	// Request is dropped in the ready cycle so the ending edge takes nothing new
	task acc(input [21:0] ad, input [2:0] k, output [4:0] cy, output [2:0] cs);
		begin
			@(posedge clk);
			#1;
			busAddr = ad;
			{busWrite, busDataSpace, busIoSpace} = k;
			busReq = 1'b1;
			@(posedge clk);
			#1;
			cy = 5'h01;
			cs = {zone01Select_n_r, zone2Select_n_r, zone67Select_n_r};
			while (busReady !== 1'b1 && cy < 5'h1E) begin
				@(posedge clk);
				#1;
				cy = cy + 5'h01;
			end
			busReq = 1'b0;
		end
	endtask
	task pulse(input prot, input d);
		begin
			{protModeWrite, bootModeWrite} = prot ? 2'h2 : 2'h1;
			protModeData = d;
			bootModeData = d;
			@(posedge clk);
			#1;
			{protModeWrite, bootModeWrite} = 2'h0;
		end
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		mismatches = 0;
		total_checks = 0;
		{busReq, busWrite, busDataSpace, busIoSpace, busAddr} = 26'h0;
		{flashWait, otpWait, zone0Wait, zone1Wait} = 16'h3002;
		{zone2Wait, zone6Wait, zone7Wait, zoneUseReady} = 17'h068A0;
		{protModeWrite, protModeData, bootModeWrite, bootModeData} = 4'h0;
		rows[0] = {22'h000010, 3'h2, 5'h01, 3'h7};
		rows[1] = {22'h009000, 3'h6, 5'h01, 3'h7};
		rows[2] = {22'h3F8000, 3'h0, 5'h01, 3'h7};
		rows[3] = {22'h000800, 3'h2, 5'h01, 3'h7};
		rows[4] = {22'h006000, 3'h0, 5'h01, 3'h7};
		rows[5] = {22'h007000, 3'h6, 5'h01, 3'h7};
		rows[6] = {22'h006010, 3'h2, 5'h04, 3'h7};
		rows[7] = {22'h006010, 3'h2, 5'h03, 3'h7};
		rows[8] = {22'h3D8000, 3'h2, 5'h04, 3'h7};
		rows[9] = {22'h3F7FF8, 3'h2, 5'h11, 3'h7};
		rows[10] = {22'h3F7FF9, 3'h6, 5'h04, 3'h7};
		rows[11] = {22'h3F7FF6, 3'h0, 5'h04, 3'h7};
		rows[12] = {22'h3D7800, 3'h2, 5'h02, 3'h7};
		rows[13] = {22'h002000, 3'h2, 5'h02, 3'h3};
		rows[14] = {22'h004000, 3'h2, 5'h03, 3'h3};
		rows[15] = {22'h080000, 3'h2, 5'h04, 3'h5};
		rows[16] = {22'h100000, 3'h2, 5'h05, 3'h6};
		rows[17] = {22'h080000, 3'h3, 5'h01, 3'h7};
		rows[18] = {22'h3FF000, 3'h0, 5'h02, 3'h7};
		rows[19] = {22'h000800, 3'h0, 5'h01, 3'h7};
		rows[20] = {22'h3F7F80, 3'h2, 5'h04, 3'h7};
		do_reset(1'b0);
		`CHK({bootSourceModeBit_r, vectorsExternal}, 2'h0)
		for (i = 0; i < 21; i = i + 1) begin
			r = rows[i];
			acc(r[32:11], r[10:8], n, s);
			`CHK(n, r[7:3])
			`CHK(s, r[2:0])
		end
		acc(22'h3F7FF6, 3'h0, n, s);
		`CHK(selBootEntry_r, 1'b1)
		pulse(1'b1, 1'b0);
		`CHK(protMode_r, 1'b0)
		acc(22'h007000, 3'h6, n, s);
		acc(22'h006010, 3'h2, n, s);
		`CHK(n, 5'h03)
		zoneUseReady = 5'h04;
		acc(22'h080000, 3'h2, n, s);
		`CHK(n > 5'h04, 1'b1)
		zoneUseReady = 5'h00;
		do_reset(1'b1);
		`CHK({protMode_r, bootSourceModeBit_r, vectorsExternal}, 3'h7)
		acc(22'h3FF000, 3'h0, n, s);
		`CHK({n, s}, {5'h06, 3'h6})
		acc(22'h3F8000, 3'h0, n, s);
		`CHK(n, 5'h01)
		pulse(1'b0, 1'b0);
		acc(22'h3FF000, 3'h0, n, s);
		`CHK({n, s, selBootRom_r}, {5'h02, 3'h7, 1'b1})
		stop_test;
	end
	initial begin
		#100000;
		mismatches = mismatches + 1;
		stop_test;
	end
endmodule
bind mmd_decoder mmd_decoder_checker chk (.*);
